// ===== design/ccr_pkg.sv
// ----------------------------------------------------------------
// Charge counter readback constants
// ----------------------------------------------------------------
package ccr_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int unsigned NUM_CH   = 3;
   localparam int unsigned CNT_W    = 16;
   localparam int unsigned BYTE_W   = 8;
   localparam int unsigned PRESC_W  = 3;
   localparam int unsigned SYNC_LEN = 3;

   // Channel indices
   localparam int unsigned CH_OUT_A     = 0;
   localparam int unsigned CH_OUT_B_ACT = 1;
   localparam int unsigned CH_OUT_B_SLP = 2;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CHARGE_COUNTER_CONTROL = 8'h10;
   localparam logic [7:0] OFS_OUT_A_HIGH             = 8'h13;
   localparam logic [7:0] OFS_OUT_A_LOW              = 8'h14;
   localparam logic [7:0] OFS_OUT_B_ACTIVE_HIGH      = 8'h15;
   localparam logic [7:0] OFS_OUT_B_ACTIVE_LOW       = 8'h16;
   localparam logic [7:0] OFS_OUT_B_SLEEP_HIGH       = 8'h17;
   localparam logic [7:0] OFS_OUT_B_SLEEP_LOW        = 8'h18;

   localparam logic [NUM_CH-1:0][7:0] HIGH_OFS = {OFS_OUT_B_SLEEP_HIGH, OFS_OUT_B_ACTIVE_HIGH, OFS_OUT_A_HIGH};
   localparam logic [NUM_CH-1:0][7:0] LOW_OFS  = {OFS_OUT_B_SLEEP_LOW, OFS_OUT_B_ACTIVE_LOW, OFS_OUT_A_LOW};

   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int unsigned         PRESC_POS   = 0;
   localparam logic [PRESC_W-1:0]  PRESC_RST   = 3'h0;
   localparam logic [CNT_W-1:0]    CNT_RST     = 16'h0000;
   localparam logic [BYTE_W-1:0]   BYTE_RST    = 8'h00;
   localparam logic [BYTE_W-1:0]   UNMAPPED_RD = 8'h00;

   // ----------------------------------------------------------------
   // State of the block
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [SYNC_LEN-1:0]            a_sync;
      logic [SYNC_LEN-1:0]            b_sync;
      logic [SYNC_LEN-1:0]            m_sync;
      logic                           a_lvl;
      logic                           b_lvl;
      logic                           sleep_lvl;
      logic [PRESC_W-1:0]             presc;
      logic [NUM_CH-1:0][BYTE_W-1:0]  pre;
      logic [NUM_CH-1:0][CNT_W-1:0]   cnt;
      logic [NUM_CH-1:0][BYTE_W-1:0]  shadow;
      logic [BYTE_W-1:0]              rdata;
   } ccr_state_t;

endpackage : ccr_pkg

// ===== design/ccr_top.sv
// Contract
// - Output A low byte, bits 7:0, resets 0x00
// - Output B active high byte at 0x15
// - Output B active low byte at 0x16, resets zero
// - Output B deep-sleep high byte, resets 0x00
// - One count per prescaled group of pulses
// - Counter spans high and low byte, live
// - Addressing a counter freezes its updates
// - Pulses during freeze are lost
// - High byte read copies low into shadow
// - Low byte read returns shadow value
//
`timescale 1ns/1ps
`default_nettype none

module ccr_top (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wr_data,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   output logic      [7:0] rd_data,
   input  wire logic       output_a_pulse,
   input  wire logic       output_b_pulse,
   input  wire logic       deep_sleep_energy_mode
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   ccr_pkg::ccr_state_t s_q;
   ccr_pkg::ccr_state_t s_d;

   logic [ccr_pkg::NUM_CH-1:0] hit_high;
   logic [ccr_pkg::NUM_CH-1:0] hit_low;
   logic [ccr_pkg::NUM_CH-1:0] frozen;
   logic [ccr_pkg::NUM_CH-1:0] pulse_ev;
   logic [ccr_pkg::NUM_CH-1:0] wrap;
   logic [ccr_pkg::NUM_CH-1:0] inc;
   logic                       a_rise;
   logic                       b_rise;
   logic                       acc;
   logic                       hit_ctrl;
   logic [7:0]                 grp_last;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // Any strobe counts as addressing; a write to a read-only counter
   // byte still freezes it, as the pin-level access would.
   // Only the strobe cycle freezes, so an address left on the bus
   // between accesses costs no counts.
   assign acc      = rd_en | wr_en;
   assign hit_ctrl = (addr == ccr_pkg::OFS_CHARGE_COUNTER_CONTROL);

   always_comb begin
      for (int i = 0; i < ccr_pkg::NUM_CH; i++) begin
         hit_high[i] = (addr == ccr_pkg::HIGH_OFS[i]);
         hit_low[i]  = (addr == ccr_pkg::LOW_OFS[i]);
         frozen[i]   = acc & (hit_high[i] | hit_low[i]);
      end
   end

   // ----------------------------------------------------------------
   // Pulse qualification
   // ----------------------------------------------------------------
   // A pin change is accepted only once the second and third stages
   // agree; the first stage feeds nothing but the second.
   assign a_rise = (s_q.a_sync[1] == s_q.a_sync[2]) & s_q.a_sync[2] & ~s_q.a_lvl;
   assign b_rise = (s_q.b_sync[1] == s_q.b_sync[2]) & s_q.b_sync[2] & ~s_q.b_lvl;

   // Group size is two to the power of the prescaler field
   assign grp_last = 8'((9'h001 << s_q.presc) - 9'h001);

   always_comb begin
      pulse_ev[ccr_pkg::CH_OUT_A]     = a_rise;
      pulse_ev[ccr_pkg::CH_OUT_B_ACT] = b_rise & ~s_q.sleep_lvl;
      pulse_ev[ccr_pkg::CH_OUT_B_SLP] = b_rise & s_q.sleep_lvl;
      for (int i = 0; i < ccr_pkg::NUM_CH; i++) begin
         wrap[i] = (s_q.pre[i] == grp_last);
         // Pulses that land in a frozen cycle are dropped outright
         inc[i]  = pulse_ev[i] & wrap[i] & ~frozen[i];
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;

      s_d.a_sync = {s_q.a_sync[1:0], output_a_pulse};
      s_d.b_sync = {s_q.b_sync[1:0], output_b_pulse};
      s_d.m_sync = {s_q.m_sync[1:0], deep_sleep_energy_mode};
      if (s_q.a_sync[1] == s_q.a_sync[2]) begin
         s_d.a_lvl = s_q.a_sync[2];
      end
      if (s_q.b_sync[1] == s_q.b_sync[2]) begin
         s_d.b_lvl = s_q.b_sync[2];
      end
      if (s_q.m_sync[1] == s_q.m_sync[2]) begin
         s_d.sleep_lvl = s_q.m_sync[2];
      end

      if (wr_en && hit_ctrl) begin
         s_d.presc = wr_data[ccr_pkg::PRESC_POS +: ccr_pkg::PRESC_W];
      end

      for (int i = 0; i < ccr_pkg::NUM_CH; i++) begin
         if (pulse_ev[i] && !frozen[i]) begin
            if (wrap[i]) begin
               s_d.pre[i] = ccr_pkg::BYTE_RST;
            end else begin
               s_d.pre[i] = s_q.pre[i] + 8'h01;
            end
         end
         if (inc[i]) begin
            s_d.cnt[i] = s_q.cnt[i] + 16'h0001;
         end
         if (rd_en && hit_high[i]) begin
            // Counter is frozen this cycle, so the pair is coherent
            s_d.shadow[i] = s_q.cnt[i][7:0];
         end
      end

      // A new group size restarts every partial group, so the
      // prescaler never sits beyond the last step of the new size
      if (wr_en && hit_ctrl) begin
         for (int i = 0; i < ccr_pkg::NUM_CH; i++) begin
            s_d.pre[i] = ccr_pkg::BYTE_RST;
         end
      end

      s_d.rdata = ccr_pkg::UNMAPPED_RD;
      if (rd_en) begin
         if (hit_ctrl) begin
            s_d.rdata = 8'(s_q.presc);
         end
         for (int i = 0; i < ccr_pkg::NUM_CH; i++) begin
            if (hit_high[i]) begin
               s_d.rdata = s_q.cnt[i][15:8];
            end
            if (hit_low[i]) begin
               s_d.rdata = s_q.shadow[i];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Reset branch holds constants only; the whole struct is cleared
   // so no stale prescaler step survives a reset.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_q.a_sync    <= 3'h0;
         s_q.b_sync    <= 3'h0;
         s_q.m_sync    <= 3'h0;
         s_q.a_lvl     <= 1'b0;
         s_q.b_lvl     <= 1'b0;
         s_q.sleep_lvl <= 1'b0;
         s_q.presc     <= ccr_pkg::PRESC_RST;
         for (int i = 0; i < ccr_pkg::NUM_CH; i++) begin
            s_q.pre[i]    <= ccr_pkg::BYTE_RST;
            s_q.cnt[i]    <= ccr_pkg::CNT_RST;
            s_q.shadow[i] <= ccr_pkg::BYTE_RST;
         end
         s_q.rdata     <= ccr_pkg::BYTE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign rd_data = s_q.rdata;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   chk_reset_low_zero: assert property (
      $rose(reset_n) |-> (s_q.cnt[ccr_pkg::CH_OUT_A][7:0] == 8'h00) && (s_q.shadow[ccr_pkg::CH_OUT_A] == 8'h00))
      else $error("output A low byte not zero after reset");

   chk_b_act_high: assert property (
      (rd_en && addr == ccr_pkg::OFS_OUT_B_ACTIVE_HIGH)
      |=> rd_data == $past(s_q.cnt[ccr_pkg::CH_OUT_B_ACT][15:8]))
      else $error("output B active high byte read wrong");

   chk_b_act_low_reset: assert property (
      $rose(reset_n) |-> (s_q.shadow[ccr_pkg::CH_OUT_B_ACT] == 8'h00) && (rd_data == 8'h00)
      && (s_q.cnt[ccr_pkg::CH_OUT_B_ACT][7:0] == 8'h00))
      else $error("output B active low byte not zero after reset");

   chk_sleep_only_count: assert property (
      !s_q.sleep_lvl |=> s_q.cnt[ccr_pkg::CH_OUT_B_SLP] == $past(s_q.cnt[ccr_pkg::CH_OUT_B_SLP]))
      else $error("deep-sleep counter moved in active mode");

   chk_prescale_group: assert property (
      (s_q.cnt[0] != s_d.cnt[0]) |-> (s_q.pre[0] == grp_last) && a_rise)
      else $error("output A counted without a full pulse group");

   chk_count_step: assert property (
      ##1 (s_q.cnt[1] != $past(s_q.cnt[1])) |-> s_q.cnt[1] == 16'($past(s_q.cnt[1]) + 16'h0001))
      else $error("output B active counter stepped by more than one");

   chk_freeze_hold: assert property (
      (acc && (addr == ccr_pkg::OFS_OUT_A_HIGH || addr == ccr_pkg::OFS_OUT_A_LOW))
      |=> s_q.cnt[0] == $past(s_q.cnt[0]) && s_q.pre[0] == $past(s_q.pre[0]))
      else $error("output A counter moved while addressed");

   chk_freeze_drop: assert property (
      frozen[0] && pulse_ev[0] ##1 1'b1
      |=> s_q.cnt[0] == $past(s_q.cnt[0], 2) && s_q.pre[0] == $past(s_q.pre[0], 2))
      else $error("output A pulse during freeze was kept");

   chk_shadow_capture: assert property (
      (rd_en && addr == ccr_pkg::OFS_OUT_B_SLEEP_HIGH)
      |=> s_q.shadow[2] == $past(s_q.cnt[2][7:0]))
      else $error("shadow not loaded on high byte read");

   chk_low_from_shadow: assert property (
      (rd_en && addr == ccr_pkg::OFS_OUT_A_LOW) ##1 (!rd_en || addr != ccr_pkg::OFS_OUT_A_HIGH) [*1]
      |-> rd_data == $past(s_q.shadow[0]))
      else $error("low byte read did not return shadow");

   chk_pair_coherent: assert property (
      (rd_en && addr == ccr_pkg::OFS_OUT_A_HIGH) ##1 (rd_en && addr == ccr_pkg::OFS_OUT_A_LOW)
      |=> rd_data == $past(s_q.cnt[0][7:0], 2))
      else $error("high then low read not coherent");

   chk_unmapped_zero: assert property (
      (rd_en && addr > ccr_pkg::OFS_OUT_B_SLEEP_LOW) |=> rd_data == ccr_pkg::UNMAPPED_RD)
      else $error("unmapped read not zero");

   chk_unmapped_low: assert property (
      (rd_en && addr < ccr_pkg::OFS_CHARGE_COUNTER_CONTROL) |=> rd_data == ccr_pkg::UNMAPPED_RD)
      else $error("read below control register not zero");

   chk_rdata_idle: assert property (
      !rd_en |=> rd_data == ccr_pkg::UNMAPPED_RD)
      else $error("read data not cleared after read cycle");

   chk_rdata_ctrl: assert property (
      (rd_en && hit_ctrl) |=> rd_data == 8'($past(s_q.presc)))
      else $error("control register read back wrong");

   // ----------------------------------------------------------------
   // Checks on the remaining channels
   // ----------------------------------------------------------------
   // Each channel gets its own copy so that a slip in one index
   // of the offset tables cannot hide behind another channel.
   chk_a_high_read: assert property (
      (rd_en && addr == ccr_pkg::OFS_OUT_A_HIGH)
      |=> rd_data == $past(s_q.cnt[ccr_pkg::CH_OUT_A][15:8]))
      else $error("output A high byte read wrong");

   chk_b_slp_high_read: assert property (
      (rd_en && addr == ccr_pkg::OFS_OUT_B_SLEEP_HIGH)
      |=> rd_data == $past(s_q.cnt[ccr_pkg::CH_OUT_B_SLP][15:8]))
      else $error("deep-sleep high byte read wrong");

   chk_a_shadow_capture: assert property (
      (rd_en && addr == ccr_pkg::OFS_OUT_A_HIGH)
      |=> s_q.shadow[ccr_pkg::CH_OUT_A] == $past(s_q.cnt[ccr_pkg::CH_OUT_A][7:0]))
      else $error("output A shadow not loaded on high byte read");

   chk_b_act_shadow: assert property (
      (rd_en && addr == ccr_pkg::OFS_OUT_B_ACTIVE_HIGH)
      |=> s_q.shadow[ccr_pkg::CH_OUT_B_ACT] == $past(s_q.cnt[ccr_pkg::CH_OUT_B_ACT][7:0]))
      else $error("output B active shadow not loaded on high byte read");

   chk_b_act_low_read: assert property (
      (rd_en && addr == ccr_pkg::OFS_OUT_B_ACTIVE_LOW)
      |=> rd_data == $past(s_q.shadow[ccr_pkg::CH_OUT_B_ACT]))
      else $error("output B active low byte did not return shadow");

   chk_b_slp_low_read: assert property (
      (rd_en && addr == ccr_pkg::OFS_OUT_B_SLEEP_LOW)
      |=> rd_data == $past(s_q.shadow[ccr_pkg::CH_OUT_B_SLP]))
      else $error("deep-sleep low byte did not return shadow");

   chk_shadow_hold: assert property (
      !(rd_en && hit_high[ccr_pkg::CH_OUT_A])
      |=> s_q.shadow[ccr_pkg::CH_OUT_A] == $past(s_q.shadow[ccr_pkg::CH_OUT_A]))
      else $error("output A shadow changed without a high byte read");

   // ----------------------------------------------------------------
   // Freeze and mode checks
   // ----------------------------------------------------------------
   // A write strobe freezes as well as a read strobe, since both
   // address the counter.
   chk_b_act_freeze: assert property (
      (acc && (addr == ccr_pkg::OFS_OUT_B_ACTIVE_HIGH || addr == ccr_pkg::OFS_OUT_B_ACTIVE_LOW))
      |=> s_q.cnt[1] == $past(s_q.cnt[1]) && s_q.pre[1] == $past(s_q.pre[1]))
      else $error("output B active counter moved while addressed");

   chk_b_slp_freeze: assert property (
      (acc && (addr == ccr_pkg::OFS_OUT_B_SLEEP_HIGH || addr == ccr_pkg::OFS_OUT_B_SLEEP_LOW))
      |=> s_q.cnt[2] == $past(s_q.cnt[2]) && s_q.pre[2] == $past(s_q.pre[2]))
      else $error("deep-sleep counter moved while addressed");

   chk_active_only_count: assert property (
      s_q.sleep_lvl |=> s_q.cnt[ccr_pkg::CH_OUT_B_ACT] == $past(s_q.cnt[ccr_pkg::CH_OUT_B_ACT]))
      else $error("active counter moved in deep-sleep mode");

   // ----------------------------------------------------------------
   // Counting checks
   // ----------------------------------------------------------------
   // The prescaler is cleared on every control write, which keeps
   // its step inside the current group size.
   chk_a_count_step: assert property (
      1'b1 |=> (s_q.cnt[0] == $past(s_q.cnt[0])) || (s_q.cnt[0] == 16'($past(s_q.cnt[0]) + 16'h0001)))
      else $error("output A counter stepped by more than one");

   chk_slp_count_step: assert property (
      1'b1 |=> (s_q.cnt[2] == $past(s_q.cnt[2])) || (s_q.cnt[2] == 16'($past(s_q.cnt[2]) + 16'h0001)))
      else $error("deep-sleep counter stepped by more than one");

   chk_prescale_b_act: assert property (
      (s_q.cnt[1] != s_d.cnt[1]) |-> (s_q.pre[1] == grp_last) && pulse_ev[1] && !frozen[1])
      else $error("output B active counted without a full pulse group");

   chk_prescale_b_slp: assert property (
      (s_q.cnt[2] != s_d.cnt[2]) |-> (s_q.pre[2] == grp_last) && pulse_ev[2] && !frozen[2])
      else $error("deep-sleep counted without a full pulse group");

   chk_pre_in_group: assert property (
      (s_q.pre[0] <= grp_last) && (s_q.pre[1] <= grp_last) && (s_q.pre[2] <= grp_last))
      else $error("prescaler step beyond group size");

   chk_ctrl_write: assert property (
      (wr_en && hit_ctrl) |=> s_q.presc == $past(wr_data[ccr_pkg::PRESC_POS +: ccr_pkg::PRESC_W]))
      else $error("prescaler field not written");

endmodule // ccr_top

`default_nettype wire

// ===== verif/ccr_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module ccr_top_tb;

   // ----------------------------------------------------------------
   // Clock, reset and ports
   // ----------------------------------------------------------------
   logic       clk;
   logic       reset_n;
   logic [7:0] addr;
   logic [7:0] wr_data;
   logic       wr_en;
   logic       rd_en;
   logic [7:0] rd_data;
   logic       pin_a;
   logic       pin_b;
   logic       sleep_mode;
   int         fails;
   int         checked;

   initial clk = 1'b0;
   always #4 clk = ~clk;

   ccr_top dut_u (
      .clk                    (clk),
      .reset_n                (reset_n),
      .addr                   (addr),
      .wr_data                (wr_data),
      .wr_en                  (wr_en),
      .rd_en                  (rd_en),
      .rd_data                (rd_data),
      .output_a_pulse         (pin_a),
      .output_b_pulse         (pin_b),
      .deep_sleep_energy_mode (sleep_mode)
   );

   // ----------------------------------------------------------------
   // Bus and pulse tasks
   // ----------------------------------------------------------------
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_en   <= 1'b1;
      addr    <= a;
      wr_data <= d;
      @(posedge clk);
      wr_en   <= 1'b0;
   endtask

   // Data stands only in the cycle after the strobe
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd_en <= 1'b1;
      addr  <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      cmp(rd_data, exp);
   endtask

   // High then low with no gap between the strobes
   task automatic rd_pair(input logic [7:0] a, input logic [7:0] exp_hi, input logic [7:0] exp_lo);
      @(posedge clk);
      rd_en <= 1'b1;
      addr  <= a;
      @(posedge clk);
      addr  <= a + 8'h01;
      #1;
      cmp(rd_data, exp_hi);
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      cmp(rd_data, exp_lo);
   endtask

   // Pins pass a 3-flop filter, so keep both phases above 3 cycles
   task automatic pulses(input bit on_b, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         if (on_b) pin_b <= 1'b1; else pin_a <= 1'b1;
         repeat (4) @(posedge clk);
         if (on_b) pin_b <= 1'b0; else pin_a <= 1'b0;
         repeat (4) @(posedge clk);
      end
      repeat (6) @(posedge clk);
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge clk);
      fails++;
      wrap_up();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      reset_n = 1'b0; addr = 8'h00; wr_data = 8'h00; wr_en = 1'b0;
      rd_en = 1'b0; pin_a = 1'b0; pin_b = 1'b0; sleep_mode = 1'b0;
      fails = 0; checked = 0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);

      for (int o = 8'h13; o <= 8'h18; o++) chk_rd(8'(o), 8'h00);
      chk_rd(8'h10, 8'h00);
      chk_rd(8'h40, 8'h00);
      $display("test reset done");

      pulses(1'b0, 3);
      chk_rd(8'h13, 8'h00);
      chk_rd(8'h14, 8'h03);
      $display("test count a done");

      // Counter bytes ignore writes
      wr(8'h16, 8'hff);
      chk_rd(8'h15, 8'h00);
      chk_rd(8'h16, 8'h00);
      wr(8'h10, 8'h01);
      chk_rd(8'h10, 8'h01);
      pulses(1'b1, 4);
      chk_rd(8'h15, 8'h00);
      chk_rd(8'h16, 8'h02);
      $display("test prescaled b done");

      sleep_mode <= 1'b1;
      repeat (6) @(posedge clk);
      pulses(1'b1, 2);
      chk_rd(8'h17, 8'h00);
      chk_rd(8'h18, 8'h01);
      chk_rd(8'h15, 8'h00);
      chk_rd(8'h16, 8'h02);
      sleep_mode <= 1'b0;
      wr(8'h10, 8'h00);
      $display("test sleep b done");

      chk_rd(8'h13, 8'h00);
      pulses(1'b0, 2);
      chk_rd(8'h14, 8'h03);
      chk_rd(8'h13, 8'h00);
      chk_rd(8'h14, 8'h05);
      $display("test shadow done");

      // Addressing the counter through the whole pulse drops it
      fork
         pulses(1'b0, 1);
         begin
            for (int i = 0; i < 14; i++) begin
               @(posedge clk);
               rd_en <= 1'b1;
               addr  <= 8'h14;
            end
            @(posedge clk);
            rd_en <= 1'b0;
         end
      join
      chk_rd(8'h13, 8'h00);
      chk_rd(8'h14, 8'h05);
      $display("test freeze done");

      pulses(1'b0, 251);
      chk_rd(8'h13, 8'h01);
      chk_rd(8'h14, 8'h00);
      rd_pair(8'h13, 8'h01, 8'h00);
      $display("test carry done");

      wrap_up();
   end

endmodule // ccr_top_tb

`default_nettype wire
